//--- src/ebc_regs.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 32-bit classic Wishbone, byte addressed, word aligned
// Notes: shared by the decode block and its bench
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH
`define EBC_NUM_CH 8
`define EBC_OFS_CH_STRIDE 8'h08
`define EBC_OFS_CH_HI 8'h04
`define EBC_OFS_GLOBAL 8'h40
`define EBC_OFS_STATUS 8'h44
`define EBC_LO_MASK 32'h81ff_ffff
`define EBC_HI_MASK 32'h0000_ffff
`define EBC_F_SIZE 0
`define EBC_F_WIDTH 4
`define EBC_F_RATE 6
`define EBC_F_LANE 8
`define EBC_F_WAIT 9
`define EBC_F_PAGE 11
`define EBC_F_PSIZE 12
`define EBC_F_BURST 14
`define EBC_F_SETUP 16
`define EBC_F_HOLD 20
`define EBC_F_CWF 24
`define EBC_F_EN 31
`define EBC_G_ARS 0
`define EBC_G_HOLD 1
`define EBC_G_DIV 2
`define EBC_RST_ARS 1'h0
`define EBC_RST_HOLD 1'h1
`define EBC_BOOT_SIZE 4'h0
`define EBC_SIZE_MAX32 4'ha
`define EBC_SIZE_MAX16 4'h9
`define EBC_SIZE_MAX8 4'h8
`define EBC_S_DIV 13
`define EBC_S_EN 8
`define EBC_S_RATE 6
`define EBC_S_LANE 5
`define EBC_S_WAIT 4
`define EBC_S_WIDTH 0
`define EBC_LIM_QUARTER 2'h3
`define EBC_LIM_THIRD 2'h2
`define EBC_LIM_HALF 2'h1
`define EBC_LIM_FULL 2'h0
`endif

//--- src/ebc_pkg.sv
// Purpose: types of the channel decode block
// Assumes: nothing
// Notes: width codes follow the port width field encoding
package ebc_pkg;
  typedef enum logic [1:0] {
    ebc_w_rsvd,
    ebc_w_32,
    ebc_w_16,
    ebc_w_8
  } ebc_width_t;
  typedef enum logic [1:0] {
    ebc_b_incr,
    ebc_b_decr,
    ebc_b_fixed,
    ebc_b_rsvd
  } ebc_burst_t;
  typedef struct packed {
    logic enable;
    logic [15:0] base;
    logic [3:0] size;
    ebc_width_t width;
    logic [1:0] rate;
    logic lane;
    logic [1:0] wait_style;
    logic page_mode;
    logic [1:0] page_size;
    ebc_burst_t burst;
    logic cwf;
    logic [3:0] setup;
    logic [3:0] hold;
  } ebc_chan_cfg_t;
endpackage

//--- src/ebc_channel_decode.sv
// Purpose: channel configuration, address decode and bus clock divider
// Assumes: straps stable while rst_n_in is low, held three edges or more
// Notes: lowest matching channel supplies sel_cfg_out
//
// Behaviour
// [RULE_01] eight channels, each configured on its own
// [RULE_02] software sets channel enable after base address
// [RULE_03] select when masked address equals masked base
// [RULE_04] size code sets mask, codes above 1010 reserved
// [RULE_05] software avoids overlapping regions
// [RULE_06] global ack/ready select, dynamic by default
// [RULE_07] global address hold after upper strobe, default on
// [RULE_08] bus clock divider loaded from address straps
// [RULE_09] channel 0 enable loaded from strap
// [RULE_10] channel 0 rate loaded from straps
// [RULE_11] channel 0 byte lane kind from strap
// [RULE_12] channel 0 wait style inverted from strap
// [RULE_13] channel 0 port width loaded from straps
// [RULE_14] per channel data width 8, 16, 32
// [RULE_15] per channel rate full, half, third, quarter
// [RULE_16] per channel setup and hold timing fields
// [RULE_17] size limit depends on port width
// [RULE_18] page mode with 4, 8, 16 entries
// [RULE_19] dma burst decrement or fixed address
// [RULE_20] critical word first for core bursts
// [RULE_21] disabled or reserved channel never selected
`timescale 1ns/1ps
`include "ebc_regs.svh"
module ebc_channel_decode #(
  parameter int NUM_CH = `EBC_NUM_CH
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [14:0] strap_addr_in,
  input wire logic [5:0] strap_data_in,
  input wire logic [35:0] paddr_in,
  input wire logic paddr_valid_in,
  output logic [NUM_CH-1:0] chan_sel_out,
  output logic chan_hit_out,
  output ebc_pkg::ebc_chan_cfg_t sel_cfg_out,
  output logic ack_ready_select_out,
  output logic upper_latch_addr_delay_out,
  output logic [1:0] ext_clock_divider_out,
  output logic ext_bus_tick_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // ****************************************
  // strap synchroniser
  // ****************************************
  logic [14:0] s_addr_1;
  logic [14:0] s_addr;
  logic [5:0] s_data_1;
  logic [5:0] s_data;
  always_ff @(posedge clock_in) begin
    s_addr_1 <= strap_addr_in;
    s_addr <= s_addr_1;
    s_data_1 <= strap_data_in;
    s_data <= s_data_1;
  end

  logic [31:0] boot_lo;
  always_comb begin
    boot_lo = 32'h0;
    boot_lo[`EBC_F_SIZE +: 4] = `EBC_BOOT_SIZE;
    boot_lo[`EBC_F_EN] = s_addr[`EBC_S_EN]; // [RULE_09]
    boot_lo[`EBC_F_RATE +: 2] = s_addr[`EBC_S_RATE +: 2]; // [RULE_10]
    boot_lo[`EBC_F_LANE] = s_data[`EBC_S_LANE]; // [RULE_11]
    boot_lo[`EBC_F_WAIT] = ~s_data[`EBC_S_WAIT]; // [RULE_12]
    boot_lo[`EBC_F_WIDTH +: 2] = s_data[`EBC_S_WIDTH +: 2]; // [RULE_13]
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  logic req;
  logic wr;
  logic [7:0] wadr;
  assign req = wb_cyc_in && wb_stb_in;
  assign wr = req && wb_we_in && wb_ack_out;
  assign wadr = {wb_adr_in[7:2], 2'h0};

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'h0;
    end else begin
      wb_ack_out <= req && !wb_ack_out;
    end
  end

  // ****************************************
  // channel registers
  // ****************************************
  logic [31:0] lo [NUM_CH];
  logic [31:0] hi [NUM_CH];
  ebc_pkg::ebc_chan_cfg_t cfg [NUM_CH];
  logic [NUM_CH-1:0] elig;
  logic [NUM_CH-1:0] match;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch // [RULE_01]
    localparam logic [7:0] OFS_LO = 8'(i * `EBC_OFS_CH_STRIDE);
    localparam logic [7:0] OFS_HI = 8'(OFS_LO + `EBC_OFS_CH_HI);
    logic [3:0] lim;
    logic [15:0] mask;

    // enable sits in the low word, base in the high word
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        lo[i] <= (i == 0) ? boot_lo : 32'h0;
      end else if (wr && wadr == OFS_LO) begin
        lo[i] <= merge(lo[i], wb_dat_in, wb_sel_in) & `EBC_LO_MASK; // [RULE_02]
      end
    end
    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        hi[i] <= 32'h0;
      end else if (wr && wadr == OFS_HI) begin
        hi[i] <= merge(hi[i], wb_dat_in, wb_sel_in) & `EBC_HI_MASK;
      end
    end

    always_comb begin
      cfg[i].enable = lo[i][`EBC_F_EN];
      cfg[i].base = hi[i][15:0];
      cfg[i].size = lo[i][`EBC_F_SIZE +: 4];
      cfg[i].width = ebc_pkg::ebc_width_t'(lo[i][`EBC_F_WIDTH +: 2]); // [RULE_14]
      cfg[i].rate = lo[i][`EBC_F_RATE +: 2]; // [RULE_15]
      cfg[i].lane = lo[i][`EBC_F_LANE];
      cfg[i].wait_style = lo[i][`EBC_F_WAIT +: 2];
      cfg[i].page_mode = lo[i][`EBC_F_PAGE];
      cfg[i].page_size = lo[i][`EBC_F_PSIZE +: 2]; // [RULE_18]
      cfg[i].burst = ebc_pkg::ebc_burst_t'(lo[i][`EBC_F_BURST +: 2]); // [RULE_19]
      cfg[i].cwf = lo[i][`EBC_F_CWF]; // [RULE_20]
      cfg[i].setup = lo[i][`EBC_F_SETUP +: 4]; // [RULE_16]
      cfg[i].hold = lo[i][`EBC_F_HOLD +: 4]; // [RULE_16]
    end

    // ****************************************
    // decode
    // ****************************************
    always_comb begin
      case (cfg[i].width)
        ebc_pkg::ebc_w_32: lim = `EBC_SIZE_MAX32; // [RULE_17]
        ebc_pkg::ebc_w_16: lim = `EBC_SIZE_MAX16; // [RULE_17]
        ebc_pkg::ebc_w_8: lim = `EBC_SIZE_MAX8; // [RULE_17]
        default: lim = 4'h0;
      endcase
    end
    assign elig[i] = cfg[i].enable && cfg[i].width != ebc_pkg::ebc_w_rsvd
                     && cfg[i].size <= lim; // [RULE_21]
    assign mask = 16'((32'h1 << cfg[i].size) - 32'h1); // [RULE_04]
    assign match[i] = ((paddr_in[35:20] ^ cfg[i].base) & ~mask) == 16'h0; // [RULE_03]

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        chan_sel_out[i] <= 1'h0;
      end else begin
        chan_sel_out[i] <= paddr_valid_in && elig[i] && match[i]; // [RULE_03]
      end
    end

    a_gate_eligible: assert property (chan_sel_out[i] |-> $past(elig[i])) // [RULE_21]
      else $error("disabled or reserved channel selected");
    a_match_sel: assert property (paddr_valid_in && cfg[i].enable // [RULE_03]
      && cfg[i].size == 4'h0 && cfg[i].width == ebc_pkg::ebc_w_32
      && paddr_in[35:20] == cfg[i].base |=> chan_sel_out[i])
      else $error("exact base address not selected");

    // ****************************************
    // per channel checks
    // ****************************************
    a_rsvd_size: assert property (paddr_valid_in && cfg[i].size > 4'ha // [RULE_04]
      |=> !chan_sel_out[i])
      else $error("reserved size code selected");
    a_width_limit: assert property (paddr_valid_in // [RULE_17]
      && cfg[i].width == ebc_pkg::ebc_w_8 && cfg[i].size > `EBC_SIZE_MAX8
      |=> !chan_sel_out[i])
      else $error("8-bit channel above size limit selected");
    a_width_mid: assert property (paddr_valid_in // [RULE_17]
      && cfg[i].width == ebc_pkg::ebc_w_16 && cfg[i].size > `EBC_SIZE_MAX16
      |=> !chan_sel_out[i])
      else $error("16-bit channel above size limit selected");
    a_outside_miss: assert property (paddr_valid_in && cfg[i].size <= 4'ha // [RULE_04]
      && paddr_in[35:30] != cfg[i].base[15:10] |=> !chan_sel_out[i])
      else $error("address outside largest window selected");
    a_disabled_off: assert property (paddr_valid_in && !cfg[i].enable // [RULE_21]
      |=> !chan_sel_out[i])
      else $error("disabled channel selected");
    a_boot_clear: assert property ($rose(rst_n_in) // [RULE_01]
      |-> cfg[i].base == 16'h0 && (i == 0 || !cfg[i].enable))
      else $error("channel not cleared by reset");
  end

  // lowest channel wins; overlaps are software's to avoid
  logic [NUM_CH-1:0] hit;
  logic [$clog2(NUM_CH)-1:0] idx;
  assign hit = match & elig;
  always_comb begin
    idx = '0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (hit[k]) begin
        idx = k[$clog2(NUM_CH)-1:0]; // [RULE_05]
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      chan_hit_out <= 1'h0;
      sel_cfg_out <= '0;
    end else begin
      chan_hit_out <= paddr_valid_in && hit != '0;
      if (paddr_valid_in) begin
        sel_cfg_out <= cfg[idx];
      end
    end
  end

  // ****************************************
  // global options
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ack_ready_select_out <= `EBC_RST_ARS; // [RULE_06]
      upper_latch_addr_delay_out <= `EBC_RST_HOLD; // [RULE_07]
      ext_clock_divider_out <= s_addr[`EBC_S_DIV +: 2]; // [RULE_08]
    end else if (wr && wadr == `EBC_OFS_GLOBAL) begin
      if (wb_sel_in[0]) begin
        ack_ready_select_out <= wb_dat_in[`EBC_G_ARS]; // [RULE_06]
        upper_latch_addr_delay_out <= wb_dat_in[`EBC_G_HOLD]; // [RULE_07]
        ext_clock_divider_out <= wb_dat_in[`EBC_G_DIV +: 2];
      end
    end
  end

  // ****************************************
  // external bus clock divider
  // ****************************************
  logic [1:0] div_live;
  logic [1:0] cnt;
  logic [1:0] lim_div;
  always_comb begin
    case (div_live)
      2'h0: lim_div = `EBC_LIM_QUARTER;
      2'h1: lim_div = `EBC_LIM_THIRD;
      2'h2: lim_div = `EBC_LIM_HALF;
      default: lim_div = `EBC_LIM_FULL;
    endcase
  end
  assign ext_bus_tick_out = rst_n_in && cnt == lim_div; // [RULE_08]

  // new ratio is taken only at a period boundary
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnt <= 2'h0;
      div_live <= s_addr[`EBC_S_DIV +: 2];
    end else if (cnt == lim_div) begin
      cnt <= 2'h0;
      div_live <= ext_clock_divider_out;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0;
    if (wadr == `EBC_OFS_GLOBAL) begin
      rd[`EBC_G_ARS] = ack_ready_select_out;
      rd[`EBC_G_HOLD] = upper_latch_addr_delay_out;
      rd[`EBC_G_DIV +: 2] = ext_clock_divider_out;
    end else if (wadr == `EBC_OFS_STATUS) begin
      rd[7:0] = 8'(chan_sel_out);
      rd[8] = chan_hit_out;
      rd[10:9] = div_live;
    end else if (wadr < `EBC_OFS_GLOBAL) begin
      rd = wadr[2] ? hi[wadr[5:3]] : lo[wadr[5:3]];
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wb_dat_out <= 32'h0;
    end else if (req && !wb_ack_out) begin
      wb_dat_out <= rd;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_release;
    $rose(rst_n_in);
  endsequence
  sequence s_gap3;
    !ext_bus_tick_out [*3] ##1 ext_bus_tick_out;
  endsequence
  sequence s_gap2;
    !ext_bus_tick_out [*2] ##1 ext_bus_tick_out;
  endsequence
  sequence s_gap1;
    !ext_bus_tick_out ##1 ext_bus_tick_out;
  endsequence

  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held over two cycles");
  a_ack_answer: assert property (req && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered next cycle");
  a_strap_div: assert property (s_release |-> // [RULE_08]
    ext_clock_divider_out == $past(s_addr[`EBC_S_DIV +: 2]))
    else $error("divider strap not loaded");
  a_strap_enable: assert property (s_release |-> // [RULE_09]
    cfg[0].enable == $past(s_addr[`EBC_S_EN]))
    else $error("channel 0 enable strap not loaded");
  a_strap_rate: assert property (s_release |-> // [RULE_10]
    cfg[0].rate == $past(s_addr[`EBC_S_RATE +: 2]))
    else $error("channel 0 rate strap not loaded");
  a_strap_lane: assert property (s_release |-> // [RULE_11]
    cfg[0].lane == $past(s_data[`EBC_S_LANE]))
    else $error("channel 0 lane strap not loaded");
  a_strap_wait: assert property (s_release |-> // [RULE_12]
    cfg[0].wait_style[0] != $past(s_data[`EBC_S_WAIT]))
    else $error("channel 0 wait strap not inverted");
  a_strap_width: assert property (s_release |-> // [RULE_13]
    cfg[0].width == $past(s_data[`EBC_S_WIDTH +: 2]))
    else $error("channel 0 width strap not loaded");
  a_boot_size: assert property (s_release |-> cfg[0].size == `EBC_BOOT_SIZE) // [RULE_09]
    else $error("boot channel size not minimal");
  a_global_ack: assert property (s_release |-> !ack_ready_select_out) // [RULE_06]
    else $error("ack ready select not dynamic after reset");
  a_global_hold: assert property (s_release |-> upper_latch_addr_delay_out) // [RULE_07]
    else $error("address hold not set after reset");
  a_tick_quarter: assert property ($past(ext_bus_tick_out) && div_live == 2'h0 // [RULE_08]
    |-> s_gap3)
    else $error("quarter rate tick period wrong");
  a_tick_third: assert property ($past(ext_bus_tick_out) && div_live == 2'h1 // [RULE_08]
    |-> s_gap2)
    else $error("third rate tick period wrong");
  a_tick_half: assert property ($past(ext_bus_tick_out) && div_live == 2'h2 // [RULE_08]
    |-> s_gap1)
    else $error("half rate tick period wrong");
  a_tick_full: assert property (div_live == 2'h3 |-> ext_bus_tick_out) // [RULE_08]
    else $error("full rate tick missing");
  a_div_keep: assert property (!(wr && wadr == `EBC_OFS_GLOBAL) // [RULE_08]
    |=> $stable(ext_clock_divider_out))
    else $error("divider changed without a write");
  a_valid_low: assert property (!paddr_valid_in // [RULE_03]
    |=> chan_sel_out == '0 && !chan_hit_out)
    else $error("selection without a lookup");
  a_hit_any: assert property (chan_hit_out |-> chan_sel_out != '0) // [RULE_03]
    else $error("hit flagged with no channel selected");
  a_cfg_hold: assert property (!paddr_valid_in |=> $stable(sel_cfg_out))
    else $error("selected config changed without a lookup");
endmodule

//--- testbench/ebc_strap_model.sv
// Purpose: boot strap resistors on the shared address and data pins
// Assumes: straps matter only while reset is low
// Notes: once reset ends the pins carry ordinary bus traffic
`timescale 1ns/1ps
module ebc_strap_model #(
  parameter logic [14:0] ADDR_STRAP = 15'h0180,
  parameter logic [5:0] DATA_STRAP = 6'h22
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  output logic [14:0] strap_addr_out,
  output logic [5:0] strap_data_out
);
  // ************
  // pin levels
  // ************
  logic flip;
  always_ff @(posedge clock_in) begin
    flip <= rst_n_in & ~flip;
  end
  // bus traffic flips every cycle after reset, so a late strap load shows
  assign strap_addr_out = rst_n_in ? (~ADDR_STRAP ^ {15{flip}}) : ADDR_STRAP;
  assign strap_data_out = rst_n_in ? (~DATA_STRAP ^ {6{flip}}) : DATA_STRAP;
endmodule

//--- testbench/testbench.sv
// Purpose: self-checking bench of the channel decode block
// Assumes: straps give /4 divider, ch0 enabled, half rate, 16-bit
// Notes: registers reached over classic Wishbone
`timescale 1ns/1ps
`include "ebc_regs.svh"
module testbench;
  logic clock_in, rst_n_in, wb_cyc, wb_stb, wb_we, paddr_valid, ack, hit, ars, hold, tick;
  logic [3:0] wb_sel;
  logic [7:0] wb_adr, sel, sel_seen;
  logic [31:0] wb_dat, rd, rdat;
  logic [35:0] paddr;
  logic [14:0] s_addr;
  logic [5:0] s_data;
  logic [1:0] div;
  ebc_pkg::ebc_chan_cfg_t cfg;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // ************
  // instances
  // ************
  ebc_strap_model ebc_strap_model_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .strap_addr_out(s_addr), .strap_data_out(s_data));
  ebc_channel_decode ebc_channel_decode_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_sel_in(wb_sel),
    .wb_adr_in(wb_adr), .wb_dat_in(wb_dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .strap_addr_in(s_addr), .strap_data_in(s_data), .paddr_in(paddr),
    .paddr_valid_in(paddr_valid), .chan_sel_out(sel), .chan_hit_out(hit),
    .sel_cfg_out(cfg), .ack_ready_select_out(ars), .upper_latch_addr_delay_out(hold),
    .ext_clock_divider_out(div), .ext_bus_tick_out(tick));
  // ************
  // tasks
  // ************
  task automatic check(input logic [41:0] seen, input logic [41:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    @(posedge clock_in);
    while (ack !== 1'b1 && n < 16) begin
      @(posedge clock_in);
      n++;
    end
    check(n < 16, 1'b1);
    rd = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask
  task automatic look(input logic [35:0] a, input logic [7:0] exp);
    paddr <= a;
    paddr_valid <= 1'b1;
    @(posedge clock_in);
    paddr_valid <= 1'b0;
    @(posedge clock_in);
    sel_seen = sel;
    check({hit, sel_seen}, {exp != 8'h00, exp});
  endtask
  task automatic ticks(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clock_in);
      if (tick === 1'b1) c++;
    end
    check(c, exp);
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_reset();
    check({ars, hold, div}, 4'h4);
    rdchk(8'h00, 32'h8000_03a0);
    rdchk(`EBC_OFS_GLOBAL, 32'h0000_0002);
    ticks(12, 3);
    look(36'h0_000f_ffff, 8'h01);
    check(cfg.width, ebc_pkg::ebc_w_16);
    look(36'h0_0010_0000, 8'h00);
    $display("done reset and boot channel");
  endtask
  task automatic t_size();
    wb(1'b1, 8'h0c, 32'h0000_0400);
    for (int k = 0; k < 16; k++) begin
      wb(1'b1, 8'h08, 32'h8000_0010 | k);
      if (k <= 10) begin
        look(36'h0_4000_0000 + (36'h1 << (20 + k)) - 36'h1, 8'h02);
        check(cfg.base, 16'h0400);
        look(36'h0_4000_0000 + (36'h1 << (20 + k)), 8'h00);
      end else begin
        look(36'h0_4000_0000, 8'h00);
      end
    end
    $display("done size codes");
  endtask
  task automatic t_width();
    wb(1'b1, 8'h14, 32'h0000_0800);
    wb(1'b1, 8'h10, 32'h8000_0039);
    look(36'h0_8000_0000, 8'h00);
    wb(1'b1, 8'h10, 32'h8000_0038);
    look(36'h0_8000_0000, 8'h04);
    wb(1'b1, 8'h10, 32'h8000_002a);
    look(36'h0_8000_0000, 8'h00);
    wb(1'b1, 8'h10, 32'h8000_0029);
    look(36'h0_8000_0000, 8'h04);
    wb(1'b1, 8'h10, 32'h0000_0038);
    look(36'h0_8000_0000, 8'h00);
    $display("done width limits");
  endtask
  task automatic t_fields();
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h18, (i << 6) | (i << 4));
      rdchk(8'h18, (i << 6) | (i << 4));
    end
    wb(1'b1, 8'h18, 32'hffff_ffff);
    rdchk(8'h18, `EBC_LO_MASK);
    wb(1'b1, 8'h1c, 32'hffff_ffff);
    rdchk(8'h1c, `EBC_HI_MASK);
    rdchk(8'h00, 32'h8000_03a0);
    wb(1'b1, 8'h48, 32'hffff_ffff);
    rdchk(8'h48, 32'h0);
    $display("done field storage");
  endtask
  task automatic t_global();
    wb(1'b1, `EBC_OFS_GLOBAL, 32'h0000_000d);
    check({ars, hold, div}, 4'hb);
    wb_sel <= 4'he;
    wb(1'b1, `EBC_OFS_GLOBAL, 32'h0000_0000);
    check({ars, hold, div}, 4'hb);
    wb_sel <= 4'hf;
    repeat (8) @(posedge clock_in);
    ticks(4, 4);
    wb(1'b1, `EBC_OFS_GLOBAL, 32'h0000_0006);
    check({ars, hold, div}, 4'h5);
    repeat (8) @(posedge clock_in);
    ticks(12, 4);
    wb(1'b1, `EBC_OFS_GLOBAL, 32'h0000_000a);
    check({ars, hold, div}, 4'h6);
    repeat (8) @(posedge clock_in);
    ticks(12, 6);
    rdchk(`EBC_OFS_STATUS, 32'h0000_0400);
    $display("done global options");
  endtask
  task automatic t_rerst();
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    check({ars, hold, div}, 4'h4);
    rdchk(8'h00, 32'h8000_03a0);
    rdchk(8'h0c, 32'h0);
    ticks(12, 3);
    $display("done second reset");
  endtask
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ************
  // run
  // ************
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_sel = 4'hf;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    paddr = 36'h0;
    paddr_valid = 1'b0;
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_size();
    t_width();
    t_fields();
    t_global();
    t_rerst();
    finish_test();
  end
endmodule
